// ### core/pss_divider.sv
// sequential unsigned divider used to size the linear step
`timescale 1ns/10ps
module pss_divider
  import pss_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic              i_start,
  input  wire logic [63:0]       i_num,
  input  wire logic [TIME_W-1:0] i_den,
  output logic                   o_done,
  output logic [63:0]            o_quo
);

  // =====================================================================
  // state
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [6:0]  cnt;
    logic [63:0] quo;
    logic [64:0] rem;
  } pss_div_t;

  pss_div_t s_r;
  pss_div_t s_nxt;
  logic [64:0] trial;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    trial      = '0;
    if (i_start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt  = 7'h40;
      s_nxt.quo  = i_num;
      s_nxt.rem  = '0;
    end else if (s_r.busy) begin
      // restoring division, one quotient bit per cycle
      trial = {s_r.rem[63:0], s_r.quo[63]};
      s_nxt.quo = {s_r.quo[62:0], 1'b0};
      if (trial >= {33'h0, i_den}) begin
        trial       = trial - {33'h0, i_den};
        s_nxt.quo[0] = 1'b1;
      end
      s_nxt.rem = trial;
      s_nxt.cnt = s_r.cnt - 7'h01;
      if (s_r.cnt == 7'h01) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_done = s_r.done;
  assign o_quo  = s_r.quo;

endmodule // pss_divider

// ### core/pss_pkg.sv
// shared constants and types for the parameter scan sequencer
package pss_pkg;

  // =====================================================================
  // widths
  localparam int unsigned VAL_W  = 32;
  localparam int unsigned TIME_W = 32;
  localparam int unsigned NSTEP_W = 32;

  // =====================================================================
  // base tick: durations and intervals are counted in 1 us ticks
  localparam int unsigned TICK_NS     = 1000;
  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // =====================================================================
  // reset values
  localparam logic [VAL_W-1:0] PARAM_RST = 32'h0000_0000;

  // =====================================================================
  // scanned parameter selection, one of five
  typedef enum logic [2:0] {
    PSS_SEL_FREQ = 3'h0,  // internal_reference_frequency
    PSS_SEL_AMPL = 3'h1,
    PSS_SEL_DC   = 3'h2,
    PSS_SEL_AUX1 = 3'h3,
    PSS_SEL_AUX2 = 3'h4
  } pss_sel_t;
  localparam int unsigned NUM_PARAM = 5;

  // end-of-scan behaviour
  typedef enum logic [1:0] {
    PSS_END_REPEAT = 2'h0,
    PSS_END_UPDOWN = 2'h1,
    PSS_END_ONCE   = 2'h2
  } pss_end_t;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    PSS_ST_OFF   = 4'b0001,
    PSS_ST_READY = 4'b0010,
    PSS_ST_RUN   = 4'b0100,
    PSS_ST_DONE  = 4'b1000
  } pss_state_t;

endpackage

// ### core/pss_sequencer.sv
// parameter scan sequencer top: arm, start, pause, reset and ramp stepping
// How it works
// RL1 - with linear spacing, the programmed duration is the whole time from begin value to end value.
// RL2 - each step holds for the update interval, so with linear spacing a shorter interval gives more, smaller steps.
// RL3 - linear or logarithmic spacing, with repeat, up-and-down or once end modes.
// RL4 - exactly one of five parameters is selected for scanning.
// RL5 - arming loads the begin value and raises ready without stepping; configuring alone changes nothing.
// RL6 - start while armed raises run and steps from begin toward end.
// RL7 - repeat mode jumps back to begin at the end and runs again forever.
// RL8 - once mode stops at the end value, holds it, and asks the chart to pause.
// RL9 - a completed scan raises done.
// RL10 - a reset command returns to begin and clears done; the next start runs again from the start.
// RL11 - configuration changes do not touch a scan in progress; they take effect on re-arm.
// RL12 - disarm drops ready; re-arm raises it again at the begin value.
// RL13 - turning scanning off before the end restores the value held before arming.
// RL14 - begin above end gives a downward scan.
// RL15 - the scanned parameter is flagged as under scan control while armed or running.
// RL16 - the linear step is span times interval over duration, and the last step clamps to end.
`timescale 1ns/10ps
module pss_sequencer
  import pss_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  input  wire logic               i_arm,         // level: scanning enabled
  input  wire logic               i_start,       // pulse: start / resume
  input  wire logic               i_pause,       // pulse: pause while running
  input  wire logic               i_reset_scan,  // pulse: back to begin value
  input  wire logic [2:0]         i_sel,
  input  wire logic [1:0]         i_end_mode,
  input  wire logic               i_log_mode,
  input  wire logic [VAL_W-1:0]   i_begin,
  input  wire logic [VAL_W-1:0]   i_end,
  input  wire logic [TIME_W-1:0]  i_duration_us,
  input  wire logic [TIME_W-1:0]  i_interval_us,
  input  wire logic [15:0]        i_log_ratio,   // per-step multiplier, 8.8 fixed point
  input  wire logic [VAL_W-1:0]   i_live_value,  // current value of the selected parameter
  output logic [VAL_W-1:0]        o_value,
  output logic                    o_value_valid, // o_value overrides the parameter
  output logic [NUM_PARAM-1:0]    o_scan_flag,
  output logic                    o_ready,
  output logic                    o_run,
  output logic                    o_done,
  output logic                    o_chart_pause
);

  // =====================================================================
  // state
  typedef struct packed {
    pss_state_t         st;
    logic               arm_d;
    logic               paused;
    logic               down;        // direction of travel
    logic               reverse;     // up-down mode second leg
    logic               step_ok;     // step size is computed
    logic               log_m;
    pss_end_t           endm;
    pss_sel_t           sel;
    logic [VAL_W-1:0]   beg_v;
    logic [VAL_W-1:0]   end_v;
    logic [TIME_W-1:0]  ivl;
    logic [15:0]        ratio;
    logic [VAL_W-1:0]   saved;
    logic [VAL_W-1:0]   val;
    logic [VAL_W-1:0]   step;
    logic [TIME_W-1:0]  ivl_cnt;
    logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;
    logic               restore;
    logic [NUM_PARAM-1:0] flag;
    logic               chart_pause;
    logic [TIME_W-1:0]  dur;         // duration captured at arm
    logic               div_busy;
  } pss_st_t;

  pss_st_t s_r;
  pss_st_t s_nxt;

  logic        div_start;
  logic        div_done;
  logic [63:0] div_quo;
  logic [VAL_W-1:0] span;
  logic        tick;
  logic        at_end;
  logic [VAL_W-1:0] nxt_lin;
  logic [VAL_W+15:0] prod;
  logic [VAL_W-1:0] nxt_log;
  logic [VAL_W-1:0] cand;
  logic [VAL_W-1:0] tgt;
  logic [VAL_W-1:0] src;
  logic [VAL_W-1:0] back;
  logic             back_end;

  function automatic logic [NUM_PARAM-1:0] sel_onehot(input pss_sel_t s);
    sel_onehot = '0;
    if (s == PSS_SEL_FREQ) sel_onehot[0] = 1'b1;
    if (s == PSS_SEL_AMPL) sel_onehot[1] = 1'b1;
    if (s == PSS_SEL_DC)   sel_onehot[2] = 1'b1;
    if (s == PSS_SEL_AUX1) sel_onehot[3] = 1'b1;
    if (s == PSS_SEL_AUX2) sel_onehot[4] = 1'b1;
  endfunction

  // =====================================================================
  // step size: span * interval / duration, one divider shared by both legs
  assign span      = (s_r.beg_v > s_r.end_v) ? s_r.beg_v - s_r.end_v : s_r.end_v - s_r.beg_v;
  // the divider is launched once per arm, with the duration captured at arm
  assign div_start = (s_r.st == PSS_ST_READY) && !s_r.step_ok && !s_r.div_busy;

  pss_divider u_div (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_start (div_start),
    .i_num   ({32'h0, span} * {32'h0, s_r.ivl}),  // see RL16
    .i_den   ((s_r.dur == '0) ? 32'h1 : s_r.dur),  // see RL1
    .o_done  (div_done),
    .o_quo   (div_quo)
  );

  // =====================================================================
  // next candidate value
  assign tgt  = s_r.reverse ? s_r.beg_v : s_r.end_v;
  assign src  = s_r.reverse ? s_r.end_v : s_r.beg_v;
  assign tick = (s_r.tick_cnt == '0);
  assign prod = s_r.val * s_r.ratio;
  always_comb begin
    nxt_lin = s_r.down ? s_r.val - s_r.step : s_r.val + s_r.step;  // see RL14
    if (s_r.down) begin
      nxt_log = (s_r.ratio == '0) ? s_r.val : prod[VAL_W+7:8];
    end else begin
      nxt_log = prod[VAL_W+7:8];
    end
    // log spacing steps by a constant ratio; lin steps by a constant size (see RL3)
    cand = s_r.log_m ? nxt_log : nxt_lin;
    // clamp on overshoot or a stalled step so the ramp always lands on the end (see RL16)
    if (s_r.down) begin
      at_end = (cand <= tgt) || (cand >= s_r.val);
    end else begin
      at_end = (cand >= tgt) || (cand <= s_r.val);
    end
    // up-down turning point: one linear step back the other way, in log mode too
    back = s_r.down ? s_r.val + s_r.step : s_r.val - s_r.step;
    if (s_r.down) begin
      back_end = (back >= src) || (back <= s_r.val);
    end else begin
      back_end = (back <= src) || (back >= s_r.val);
    end
  end

  // =====================================================================
  // sequencer
  always_comb begin
    s_nxt         = s_r;
    s_nxt.arm_d   = i_arm;
    s_nxt.restore = 1'b0;
    s_nxt.tick_cnt = tick ? ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1) : s_r.tick_cnt - 1'b1;
    if (div_done) begin
      s_nxt.step    = (div_quo[63:VAL_W] != '0) ? span : div_quo[VAL_W-1:0];
      s_nxt.step_ok = 1'b1;
      s_nxt.div_busy = 1'b0;
    end else if (div_start) begin
      s_nxt.div_busy = 1'b1;
    end
    if (i_arm && !s_r.arm_d) begin
      // configuration is captured only here (see RL11)
      s_nxt.st      = PSS_ST_READY;                         // see RL5
      s_nxt.sel     = pss_sel_t'(i_sel);                    // see RL4
      s_nxt.endm    = pss_end_t'(i_end_mode);
      s_nxt.log_m   = i_log_mode;
      s_nxt.beg_v   = i_begin;
      s_nxt.end_v   = i_end;
      s_nxt.ivl     = (i_interval_us == '0) ? 32'h1 : i_interval_us;
      s_nxt.ratio   = i_log_ratio;
      s_nxt.dur     = i_duration_us;                        // see RL11
      s_nxt.div_busy = 1'b0;
      s_nxt.saved   = i_live_value;                         // see RL13
      s_nxt.val     = i_begin;
      s_nxt.down    = (i_begin > i_end);                    // see RL14
      s_nxt.reverse = 1'b0;
      s_nxt.paused  = 1'b0;
      s_nxt.step_ok = 1'b0;
      s_nxt.chart_pause = 1'b0;
      s_nxt.flag    = sel_onehot(pss_sel_t'(i_sel));        // see RL15
    end else if (!i_arm && s_r.arm_d) begin
      // turning off early puts the pre-scan value back (see RL13, RL12)
      if (s_r.st != PSS_ST_DONE) begin
        s_nxt.val     = s_r.saved;
        s_nxt.restore = 1'b1;
      end
      s_nxt.st   = PSS_ST_OFF;
      s_nxt.flag = '0;                                      // see RL15
      s_nxt.chart_pause = 1'b0;
    end else if (s_r.st != PSS_ST_OFF && i_reset_scan) begin
      s_nxt.st      = PSS_ST_READY;                         // see RL10
      s_nxt.val     = s_r.beg_v;
      s_nxt.down    = (s_r.beg_v > s_r.end_v);
      s_nxt.reverse = 1'b0;
      s_nxt.paused  = 1'b0;
      s_nxt.chart_pause = 1'b0;
    end else begin
      unique case (s_r.st)
        PSS_ST_OFF: begin
        end
        PSS_ST_READY: begin
          if (i_start && (s_r.step_ok || div_done)) begin
            s_nxt.st      = PSS_ST_RUN;                     // see RL6
            s_nxt.ivl_cnt = s_r.ivl - 1'b1;
            s_nxt.paused  = 1'b0;
          end
        end
        PSS_ST_RUN: begin
          if (i_pause) begin
            s_nxt.paused = 1'b1;
          end else if (i_start) begin
            s_nxt.paused = 1'b0;
          end
          if (!s_r.paused && tick) begin
            if (s_r.ivl_cnt != '0) begin
              s_nxt.ivl_cnt = s_r.ivl_cnt - 1'b1;           // see RL2
            end else begin
              s_nxt.ivl_cnt = s_r.ivl - 1'b1;
              if (s_r.val == tgt) begin
                unique case (s_r.endm)
                  PSS_END_REPEAT: begin
                    s_nxt.val = s_r.beg_v;                  // see RL7
                  end
                  PSS_END_UPDOWN: begin
                    s_nxt.reverse = !s_r.reverse;
                    s_nxt.down    = !s_r.down;
                    s_nxt.val     = back_end ? src : back;
                  end
                  default: begin
                    s_nxt.st          = PSS_ST_DONE;        // see RL8, RL9
                    s_nxt.chart_pause = 1'b1;
                  end
                endcase
              end else begin
                s_nxt.val = at_end ? tgt : cand;            // see RL16
              end
            end
          end
        end
        PSS_ST_DONE: begin
          if (i_start) begin
            s_nxt.st      = PSS_ST_RUN;
            s_nxt.val     = s_r.beg_v;
            s_nxt.down    = (s_r.beg_v > s_r.end_v);
            s_nxt.reverse = 1'b0;
            s_nxt.ivl_cnt = s_r.ivl - 1'b1;
            s_nxt.chart_pause = 1'b0;
          end
        end
        default: begin
          s_nxt.st = PSS_ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r          <= '0;
      s_r.st       <= PSS_ST_OFF;
      s_r.val      <= PARAM_RST;
      s_r.saved    <= PARAM_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // =====================================================================
  // outputs, all from flops
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_value       <= PARAM_RST;
      o_value_valid <= 1'b0;
      o_scan_flag   <= '0;
      o_ready       <= 1'b0;
      o_run         <= 1'b0;
      o_done        <= 1'b0;
      o_chart_pause <= 1'b0;
    end else begin
      o_value       <= s_nxt.val;
      o_value_valid <= (s_nxt.st != PSS_ST_OFF) || s_nxt.restore;
      o_scan_flag   <= s_nxt.flag;
      o_ready       <= (s_nxt.st == PSS_ST_READY);          // see RL12
      o_run         <= (s_nxt.st == PSS_ST_RUN) && !s_nxt.paused;
      o_done        <= (s_nxt.st == PSS_ST_DONE);           // see RL9
      o_chart_pause <= s_nxt.chart_pause;
    end
  end

endmodule // pss_sequencer

// ### verification/pss_sequencer_checker.sv
// concurrent checks on the ports of the parameter scan sequencer
`timescale 1ns/10ps
module pss_sequencer_checker
  import pss_pkg::*;
(
  input wire logic               i_clk,
  input wire logic               i_srst,
  input wire logic               i_arm,
  input wire logic               i_start,
  input wire logic               i_pause,
  input wire logic               i_reset_scan,
  input wire logic [2:0]         i_sel,
  input wire logic [1:0]         i_end_mode,
  input wire logic               i_log_mode,
  input wire logic [VAL_W-1:0]   i_begin,
  input wire logic [VAL_W-1:0]   i_end,
  input wire logic [TIME_W-1:0]  i_duration_us,
  input wire logic [TIME_W-1:0]  i_interval_us,
  input wire logic [15:0]        i_log_ratio,
  input wire logic [VAL_W-1:0]   i_live_value,
  input wire logic [VAL_W-1:0]   o_value,
  input wire logic               o_value_valid,
  input wire logic [NUM_PARAM-1:0] o_scan_flag,
  input wire logic               o_ready,
  input wire logic               o_run,
  input wire logic               o_done,
  input wire logic               o_chart_pause
);
  // =====================================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  AST_ARM_READY: assert property ($rose(i_arm) |=> o_ready && o_value == $past(i_begin))
    else $error("arm did not load begin value with ready");
  AST_DISARM_RESTORE: assert property ($fell(i_arm) && o_run |=> o_value_valid && !o_run)
    else $error("disarm mid scan did not restore");
  AST_FLAG_ONEHOT: assert property ((o_ready || o_run) |-> $onehot(o_scan_flag))
    else $error("scan flag not one-hot while armed");
  AST_READY_DRIVES: assert property (o_ready |-> o_value_valid)
    else $error("ready without value override");
  AST_READY_NO_STEP: assert property (o_ready && $past(o_ready) && $past(i_arm) |-> $stable(o_value))
    else $error("value stepped while only ready");
  AST_DONE_STOPS: assert property ($rose(o_done) |-> !o_run && o_chart_pause)
    else $error("done without stop and chart pause");
  AST_RESET_SCAN: assert property (i_reset_scan && i_arm && (o_run || o_done) ##1 i_arm |-> o_ready && !o_done)
    else $error("reset command did not return to ready");
  AST_OFF_IDLE: assert property (!i_arm |=> !o_run && !o_ready && o_scan_flag == '0)
    else $error("status or flag active while disarmed");
  AST_RUN_CAUSE: assert property ($rose(o_run) |-> $past(i_start))
    else $error("run rose without start");
endmodule // pss_sequencer_checker

bind pss_sequencer pss_sequencer_checker i_chk (.*);

// ### verification/tb_pss_sequencer.sv
// self-checking bench for the parameter scan sequencer
`timescale 1ns/10ps
module tb_pss_sequencer
  import pss_pkg::*;
;
  logic                 clk, srst, arm, start, pause, rsc, logm, vv, rdy, run, done, cpause;
  logic [2:0]           sel;
  logic [1:0]           endm;
  logic [15:0]          ratio;
  logic [VAL_W-1:0]     beg, fin, live, val;
  logic [TIME_W-1:0]    dur, ivl;
  logic [NUM_PARAM-1:0] flag;
  int                   n_errors, num_checks, cyc, last_t;

  pss_sequencer i_dut (.i_clk(clk), .i_srst(srst), .i_arm(arm), .i_start(start), .i_pause(pause),
    .i_reset_scan(rsc), .i_sel(sel), .i_end_mode(endm), .i_log_mode(logm), .i_begin(beg), .i_end(fin),
    .i_duration_us(dur), .i_interval_us(ivl), .i_log_ratio(ratio), .i_live_value(live), .o_value(val),
    .o_value_valid(vv), .o_scan_flag(flag), .o_ready(rdy), .o_run(run), .o_done(done), .o_chart_pause(cpause));

  // =====================================================================
  // clock, cycle count, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  // =====================================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_v(input logic [VAL_W-1:0] got, input logic [VAL_W-1:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp, input string m);
    chk_v(VAL_W'(got), VAL_W'(exp), m);
  endtask
  // config is applied first so that its lack of effect can be seen, then armed
  task automatic arm_cfg(input pss_sel_t s, input pss_end_t md, input logic lm, input logic [VAL_W-1:0] b,
                         input logic [VAL_W-1:0] e);
    sel = s; endm = md; logm = lm; beg = b; fin = e;
    tick(2);
    chk_b(vv, 1'b0, "config alone overrode value");
    arm = 1'b1;
    tick(1);
    chk_b(rdy, 1'b1, "ready after arm");
    chk_v(val, b, "begin value on arm");
    chk_v(VAL_W'(flag), VAL_W'(1 << s), "scan flag");
    tick(80);
    chk_v(val, b, "stepped before start");
  endtask
  task automatic go();
    start = 1'b1;
    tick(1);
    start = 1'b0;
    chk_b(run, 1'b1, "run after start");
  endtask
  // waits for the next value change; the spacing of later steps must be one interval
  task automatic step(input logic [VAL_W-1:0] exp, input logic sp);
    logic [VAL_W-1:0] old;
    old = val;
    for (int i = 0; i < 400 && val === old; i++) tick(1);
    chk_v(val, exp, "step value");
    if (sp) chk_v(VAL_W'(cyc - last_t), VAL_W'(ivl * TICK_CYCLES), "step spacing");
    last_t = cyc;
  endtask
  task automatic disarm();
    arm = 1'b0;
    tick(2);
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // =====================================================================
  // tests
  initial begin
    {arm, start, pause, rsc, logm, sel, endm} = '0;
    {n_errors, num_checks, cyc, last_t} = '0;
    beg = 32'h0000_0010; fin = 32'h0000_0050; live = 32'h0000_0077;
    dur = 32'h0000_0004; ivl = 32'h0000_0001; ratio = 16'h0100;
    srst = 1'b1;
    tick(3);
    srst = 1'b0;
    tick(1);
    chk_b(rdy, 1'b0, "ready out of reset");
    for (int s = 0; s < NUM_PARAM; s++) begin
      arm_cfg(pss_sel_t'(s), PSS_END_ONCE, 1'b0, 32'h0000_0010, 32'h0000_0050);
      disarm();
      chk_v(VAL_W'(flag), '0, "flag after disarm");
    end
    // once mode, linear, with a config change while running that must be ignored
    arm_cfg(PSS_SEL_AMPL, PSS_END_ONCE, 1'b0, 32'h0000_0010, 32'h0000_0050);
    go();
    fin = 32'h0000_0099;
    step(32'h0000_0020, 1'b0);
    step(32'h0000_0030, 1'b1);
    step(32'h0000_0040, 1'b1);
    step(32'h0000_0050, 1'b1);
    for (int i = 0; i < 300 && done !== 1'b1; i++) tick(1);
    chk_b(done, 1'b1, "done at end");
    chk_b(run, 1'b0, "run after once");
    chk_b(cpause, 1'b1, "chart pause");
    tick(150);
    chk_v(val, 32'h0000_0050, "hold end value");
    rsc = 1'b1;
    tick(1);
    rsc = 1'b0;
    chk_b(done, 1'b0, "done after reset command");
    chk_v(val, 32'h0000_0010, "begin after reset command");
    tick(2);
    go();
    step(32'h0000_0020, 1'b0);
    step(32'h0000_0030, 1'b1);
    arm = 1'b0;
    tick(1);
    chk_v(val, 32'h0000_0077, "restore on early off");
    chk_b(vv, 1'b1, "restore override");
    chk_b(rdy, 1'b0, "ready after disarm");
    tick(1);
    // downward repeat scan: jumps back to begin after the end value
    arm_cfg(PSS_SEL_AUX2, PSS_END_REPEAT, 1'b0, 32'h0000_0050, 32'h0000_0010);
    go();
    step(32'h0000_0040, 1'b0);
    step(32'h0000_0030, 1'b1);
    step(32'h0000_0020, 1'b1);
    step(32'h0000_0010, 1'b1);
    step(32'h0000_0050, 1'b1);
    step(32'h0000_0040, 1'b1);
    // pause holds the value and drops run; start resumes stepping
    pause = 1'b1;
    tick(1);
    pause = 1'b0;
    chk_b(run, 1'b0, "run while paused");
    tick(250);
    chk_v(val, 32'h0000_0040, "value held while paused");
    go();
    step(32'h0000_0030, 1'b0);
    disarm();
    // up-and-down turns back at the end value
    arm_cfg(PSS_SEL_DC, PSS_END_UPDOWN, 1'b0, 32'h0000_0010, 32'h0000_0030);
    go();
    step(32'h0000_0018, 1'b0);
    step(32'h0000_0020, 1'b1);
    step(32'h0000_0028, 1'b1);
    step(32'h0000_0030, 1'b1);
    step(32'h0000_0028, 1'b1);
    disarm();
    // logarithmic spacing, doubling each step
    ratio = 16'h0200;
    arm_cfg(PSS_SEL_FREQ, PSS_END_ONCE, 1'b1, 32'h0000_0010, 32'h0000_0080);
    go();
    step(32'h0000_0020, 1'b0);
    step(32'h0000_0040, 1'b1);
    step(32'h0000_0080, 1'b1);
    disarm();
    tally_and_finish();
  end
endmodule // tb_pss_sequencer
